//--- hw/sscc_consts.svh
// constants of the serial slave port: offsets, reset values, timing
`ifndef SSCC_CONSTS_SVH
`define SSCC_CONSTS_SVH

`define SSCC_REG_STATION 16'h0300
`define SSCC_REG_BAUD 16'h0301
`define SSCC_REG_PROTO 16'h0302
`define SSCC_REG_POLICY 16'h0303
`define SSCC_REG_TIMEOUT 16'h0304
`define SSCC_REG_RSVD 16'h0305
`define SSCC_REG_SRCMASK 16'h0306
`define SSCC_REG_DELAY 16'h0307
`define SSCC_REG_HIST0 16'h0400
`define SSCC_REG_HIST1 16'h0401
`define SSCC_REG_HIST2 16'h0402
`define SSCC_REG_SOFTIN 16'h0407

`define SSCC_RST_STATION 8'h01
`define SSCC_RST_BAUD 3'h1
`define SSCC_RST_PROTO 4'h0

`define SSCC_STATION_MIN 16'h0001
`define SSCC_STATION_MAX 16'h00fe
`define SSCC_BAUD_MAX 16'h0005
`define SSCC_PROTO_MAX 16'h0008
`define SSCC_POLICY_MAX 16'h0001
`define SSCC_TIMEOUT_MAX 16'h0014
`define SSCC_MASK_MAX 16'h003f
`define SSCC_DELAY_MAX 16'h00ff
`define SSCC_ADDR_BCAST 8'h00
`define SSCC_ADDR_AUTO 8'hff

`define SSCC_CLK_HZ 10000000
`define SSCC_CLK_NS 100
`define SSCC_BAUD_0 4800
`define SSCC_BAUD_1 9600
`define SSCC_BAUD_2 19200
`define SSCC_BAUD_3 38400
`define SSCC_BAUD_4 57600
`define SSCC_BAUD_5 115200
`define SSCC_MS_NS 1000000
`define SSCC_MS_CYCLES (`SSCC_MS_NS / `SSCC_CLK_NS)
`define SSCC_TIMEOUT_UNIT_MS 1000

`define SSCC_COMM_FAULT_CODE 16'h0011

`endif

//--- hw/sscc_pkg.sv
// types of the serial slave port
package sscc_pkg;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } sscc_rx_t;

  typedef enum logic [1:0] {
    RQ_IDLE, RQ_WAIT
  } sscc_rq_t;

  typedef struct packed {
    logic rtu;
    logic eight;
    logic parEn;
    logic parOdd;
    logic twoStop;
  } sscc_fmt_t;

  typedef struct packed {
    logic rxS1;
    logic rxS2;
    logic [5:0] dinS1;
    logic [5:0] dinS2;
    sscc_rx_t rxState;
    logic [11:0] rxCnt;
    logic [2:0] rxBit;
    logic [7:0] rxShift;
    logic rxPar;
    logic rxErr;
    logic txBusy;
    logic [11:0] txCnt;
    logic [11:0] txFrame;
    logic [3:0] txLeft;
    logic txPin;
    logic [7:0] stationAddr;
    logic [2:0] baudSel;
    logic [3:0] protoSel;
    logic faultPolicy;
    logic [4:0] timeoutSet;
    logic [5:0] srcMask;
    logic [7:0] replyDelay;
    logic [5:0] softIn;
    logic [15:0] hist0;
    logic [15:0] hist1;
    logic [15:0] hist2;
    logic [13:0] msCnt;
    logic [14:0] idleMs;
    logic commFault;
    logic stopDrive;
    logic [5:0] diOut;
    sscc_rq_t rqState;
    logic [13:0] rqCyc;
    logic [7:0] rqWaitMs;
    logic [15:0] rspData;
    logic rspError;
    logic rspValid;
  } sscc_state_t;

endpackage

//--- hw/sscc_port.sv
// serial slave port: character framing, config registers, faults, inputs
`timescale 1ns/1ns
`include "sscc_consts.svh"

module sscc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sscc_fifo_state_t;
  sscc_fifo_state_t s, n;
  logic full;
  logic empty;

  assign full = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
  assign empty = (s.wp == s.rp);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = s.mem[s.rp[AW-1:0]];

  always_comb begin
    n = s;
    if (inValid && !full) begin
      n.mem[s.wp[AW-1:0]] = inData;
      n.wp = s.wp + 1'b1;
    end
    if (outReady && !empty) begin
      n.rp = s.rp + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule

// Overview of operation
// - own station address 1..254, default 1; matching requests are ours
// - address 0 is broadcast: act on it, never answer
// - address 255 is always accepted and always answered
// - baud codes 0..5 give 4800..115200 bit/s, default code 1
// - protocol codes 0..5: ASCII 7N2,7E1,7O1,8N2,8E1,8O1; default 0
// - protocol codes 6..8: RTU 8N2, 8E1, 8O1
// - format means data bits, then parity, then stop bits
// - link fault is reported; policy 1 also stops the drive
// - timeout 0..20, 0 off; idle past it raises a link fault
// - six-bit mask picks connector or link as source of each input
// - inputs with mask bit set follow the software input register
// - answer waits 0..255 ms as set, default 0
// - requests to address 255 are answered with no delay
// - three-entry read-only fault history, all zero at reset
// - software input bit 0 is input 1 up to bit 5 for input 6
module sscc_port #(
  parameter int MS_CYCLES = `SSCC_MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic rxdPin,
  output logic txdPin,
  input wire logic [5:0] extDin,
  output logic [5:0] diState,
  output logic rxCharValid,
  input wire logic rxCharReady,
  output logic [7:0] rxCharData,
  input wire logic txCharValid,
  output logic txCharReady,
  input wire logic [7:0] txCharData,
  output logic rtuMode,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [7:0] reqStation,
  input wire logic reqWrite,
  input wire logic [15:0] reqReg,
  input wire logic [15:0] reqData,
  output logic rspValid,
  output logic [15:0] rspData,
  output logic rspError,
  input wire logic driveFaultEvt,
  input wire logic [15:0] driveFaultCode,
  input wire logic faultClear,
  output logic commFault,
  output logic stopDrive
);
  sscc_pkg::sscc_state_t s, n;
  sscc_pkg::sscc_fmt_t fmt;
  logic [11:0] div;
  logic [15:0] txBuilt;
  logic pushValid;
  logic pushReady;
  logic [7:0] pushData;
  logic commEvt;
  logic activity;
  logic msTick;
  logic taken;
  logic [14:0] idleLimit;

  function automatic sscc_pkg::sscc_fmt_t frameFmt(input logic [3:0] code);
    sscc_pkg::sscc_fmt_t f;
    f = '0;
    f.rtu = (code >= 4'h6);
    f.eight = (code >= 4'h3);
    case (code)
      4'h1, 4'h4, 4'h7: f.parEn = 1'b1;
      4'h2, 4'h5, 4'h8: begin
        f.parEn = 1'b1;
        f.parOdd = 1'b1;
      end
      default: f.twoStop = 1'b1;
    endcase
    return f;
  endfunction

  // cycles per bit; truncation keeps the error under 1 % at 115200
  function automatic logic [11:0] baudDiv(input logic [2:0] code);
    case (code)
      3'h0: return 12'(`SSCC_CLK_HZ / `SSCC_BAUD_0);
      3'h1: return 12'(`SSCC_CLK_HZ / `SSCC_BAUD_1);
      3'h2: return 12'(`SSCC_CLK_HZ / `SSCC_BAUD_2);
      3'h3: return 12'(`SSCC_CLK_HZ / `SSCC_BAUD_3);
      3'h4: return 12'(`SSCC_CLK_HZ / `SSCC_BAUD_4);
      default: return 12'(`SSCC_CLK_HZ / `SSCC_BAUD_5);
    endcase
  endfunction

  // returns {length, frame}; unused high bits are idle ones
  function automatic logic [15:0] buildFrame(input sscc_pkg::sscc_fmt_t f,
                                             input logic [7:0] d);
    logic [11:0] fr;
    logic [3:0] pos;
    logic p;
    fr = '1;
    fr[0] = 1'b0;
    p = f.parOdd;
    for (int i = 0; i < 8; i++) begin
      if (i < 7 || f.eight) begin
        fr[i+1] = d[i];
        p = p ^ d[i];
      end
    end
    pos = f.eight ? 4'h9 : 4'h8;
    if (f.parEn) begin
      fr[pos] = p;
      pos = pos + 4'h1;
    end
    pos = pos + (f.twoStop ? 4'h2 : 4'h1);
    return {pos, fr};
  endfunction

  function automatic logic inRange(input logic [15:0] v,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  sscc_fifo #(.WIDTH(8), .DEPTH(8)) rxFifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(rxCharValid),
    .outReady(rxCharReady),
    .outData(rxCharData)
  );

  assign fmt = frameFmt(s.protoSel);
  assign div = baudDiv(s.baudSel);
  assign txBuilt = buildFrame(fmt, txCharData);
  assign msTick = (s.msCnt == 14'(MS_CYCLES - 1));
  assign idleLimit = 15'(s.timeoutSet * `SSCC_TIMEOUT_UNIT_MS);
  assign txCharReady = !s.txBusy;
  assign reqReady = (s.rqState == sscc_pkg::RQ_IDLE);
  assign taken = reqValid && reqReady;
  assign txdPin = s.txPin;
  assign rtuMode = fmt.rtu;
  assign diState = s.diOut;
  assign rspValid = s.rspValid;
  assign rspData = s.rspData;
  assign rspError = s.rspError;
  assign commFault = s.commFault;
  assign stopDrive = s.stopDrive;

  always_comb begin
    n = s;
    pushValid = 1'b0;
    pushData = fmt.eight ? s.rxShift : {1'b0, s.rxShift[7:1]};
    commEvt = 1'b0;
    activity = 1'b0;
    n.rxS1 = rxdPin;
    n.rxS2 = s.rxS1;
    n.dinS1 = extDin;
    n.dinS2 = s.dinS1;
    n.rspValid = 1'b0;
    n.msCnt = msTick ? '0 : s.msCnt + 1'b1;

    // receiver; the line is sampled in the middle of each bit
    if (s.rxState != sscc_pkg::RX_IDLE) begin
      n.rxCnt = s.rxCnt - 1'b1;
    end
    case (s.rxState)
      sscc_pkg::RX_IDLE: begin
        if (!s.rxS2) begin
          n.rxState = sscc_pkg::RX_START;
          n.rxCnt = div >> 1;
        end
      end
      sscc_pkg::RX_START: begin
        if (s.rxCnt == '0) begin
          n.rxCnt = div - 1'b1;
          n.rxBit = '0;
          n.rxErr = 1'b0;
          n.rxPar = fmt.parOdd;
          n.rxState = s.rxS2 ? sscc_pkg::RX_IDLE : sscc_pkg::RX_DATA;
        end
      end
      sscc_pkg::RX_DATA: begin
        if (s.rxCnt == '0) begin
          n.rxCnt = div - 1'b1;
          n.rxShift = {s.rxS2, s.rxShift[7:1]};
          n.rxPar = s.rxPar ^ s.rxS2;
          n.rxBit = s.rxBit + 1'b1;
          if (s.rxBit == (fmt.eight ? 3'h7 : 3'h6)) begin
            n.rxBit = '0;
            n.rxState = fmt.parEn ? sscc_pkg::RX_PAR : sscc_pkg::RX_STOP;
          end
        end
      end
      sscc_pkg::RX_PAR: begin
        if (s.rxCnt == '0) begin
          n.rxCnt = div - 1'b1;
          n.rxErr = s.rxPar ^ s.rxS2;
          n.rxState = sscc_pkg::RX_STOP;
        end
      end
      sscc_pkg::RX_STOP: begin
        if (s.rxCnt == '0) begin
          n.rxCnt = div - 1'b1;
          n.rxErr = s.rxErr | !s.rxS2;
          if (fmt.twoStop && s.rxBit == '0 && s.rxS2) begin
            n.rxBit = 3'h1;
          end else begin
            n.rxState = sscc_pkg::RX_IDLE;
            activity = 1'b1;
            // the line cannot be stalled, so a full queue loses the char
            if (s.rxErr || !s.rxS2 || !pushReady) begin
              commEvt = 1'b1;
            end else begin
              pushValid = 1'b1;
            end
          end
        end
      end
      default: n.rxState = sscc_pkg::RX_IDLE;
    endcase

    // transmitter shifts a prebuilt frame out, start bit first
    if (!s.txBusy) begin
      if (txCharValid) begin
        n.txBusy = 1'b1;
        n.txPin = txBuilt[0];
        n.txFrame = {1'b1, txBuilt[11:1]};
        n.txLeft = txBuilt[15:12] - 1'b1;
        n.txCnt = div - 1'b1;
      end
    end else if (s.txCnt != '0) begin
      n.txCnt = s.txCnt - 1'b1;
    end else if (s.txLeft == '0) begin
      n.txBusy = 1'b0;
      n.txPin = 1'b1;
    end else begin
      n.txPin = s.txFrame[0];
      n.txFrame = {1'b1, s.txFrame[11:1]};
      n.txLeft = s.txLeft - 1'b1;
      n.txCnt = div - 1'b1;
    end

    // register requests from the frame codec
    if (s.rqState == sscc_pkg::RQ_WAIT) begin
      n.rqCyc = s.rqCyc + 1'b1;
      if (s.rqCyc == 14'(MS_CYCLES - 1)) begin
        n.rqCyc = '0;
        n.rqWaitMs = s.rqWaitMs - 1'b1;
        if (s.rqWaitMs == 8'h01) begin
          n.rspValid = 1'b1;
          n.rqState = sscc_pkg::RQ_IDLE;
        end
      end
    end
    if (taken && (reqStation == `SSCC_ADDR_BCAST ||
                  reqStation == `SSCC_ADDR_AUTO ||
                  reqStation == s.stationAddr)) begin
      activity = 1'b1;
      n.rspData = '0;
      n.rspError = 1'b0;
      case (reqReg)
        `SSCC_REG_STATION: begin
          n.rspData = 16'(s.stationAddr);
          if (reqWrite) begin
            if (inRange(reqData, `SSCC_STATION_MIN, `SSCC_STATION_MAX))
              n.stationAddr = reqData[7:0];
            else
              n.rspError = 1'b1;
          end
        end
        `SSCC_REG_BAUD: begin
          n.rspData = 16'(s.baudSel);
          if (reqWrite) begin
            if (inRange(reqData, '0, `SSCC_BAUD_MAX))
              n.baudSel = reqData[2:0];
            else
              n.rspError = 1'b1;
          end
        end
        `SSCC_REG_PROTO: begin
          n.rspData = 16'(s.protoSel);
          if (reqWrite) begin
            if (inRange(reqData, '0, `SSCC_PROTO_MAX))
              n.protoSel = reqData[3:0];
            else
              n.rspError = 1'b1;
          end
        end
        `SSCC_REG_POLICY: begin
          n.rspData = 16'(s.faultPolicy);
          if (reqWrite) begin
            if (inRange(reqData, '0, `SSCC_POLICY_MAX))
              n.faultPolicy = reqData[0];
            else
              n.rspError = 1'b1;
          end
        end
        `SSCC_REG_TIMEOUT: begin
          n.rspData = 16'(s.timeoutSet);
          if (reqWrite) begin
            if (inRange(reqData, '0, `SSCC_TIMEOUT_MAX))
              n.timeoutSet = reqData[4:0];
            else
              n.rspError = 1'b1;
          end
        end
        `SSCC_REG_RSVD: n.rspData = '0;
        `SSCC_REG_SRCMASK: begin
          n.rspData = 16'(s.srcMask);
          if (reqWrite) begin
            if (inRange(reqData, '0, `SSCC_MASK_MAX))
              n.srcMask = reqData[5:0];
            else
              n.rspError = 1'b1;
          end
        end
        `SSCC_REG_DELAY: begin
          n.rspData = 16'(s.replyDelay);
          if (reqWrite) begin
            if (inRange(reqData, '0, `SSCC_DELAY_MAX))
              n.replyDelay = reqData[7:0];
            else
              n.rspError = 1'b1;
          end
        end
        `SSCC_REG_SOFTIN: begin
          n.rspData = 16'(s.diOut);
          if (reqWrite) begin
            if (inRange(reqData, '0, `SSCC_MASK_MAX))
              n.softIn = reqData[5:0];
            else
              n.rspError = 1'b1;
          end
        end
        `SSCC_REG_HIST0: begin
          n.rspData = s.hist0;
          n.rspError = reqWrite;
        end
        `SSCC_REG_HIST1: begin
          n.rspData = s.hist1;
          n.rspError = reqWrite;
        end
        `SSCC_REG_HIST2: begin
          n.rspData = s.hist2;
          n.rspError = reqWrite;
        end
        default: n.rspError = 1'b1;
      endcase
      if (reqStation == `SSCC_ADDR_BCAST) begin
        n.rspError = s.rspError;
        n.rspData = s.rspData;
      end else if (reqStation == `SSCC_ADDR_AUTO || s.replyDelay == '0) begin
        n.rspValid = 1'b1;
      end else begin
        n.rqState = sscc_pkg::RQ_WAIT;
        n.rqCyc = '0;
        n.rqWaitMs = s.replyDelay;
      end
    end

    // idle watchdog; fires once per silence, rearmed by traffic
    if (activity || s.timeoutSet == '0) begin
      n.idleMs = '0;
    end else if (msTick && s.idleMs != idleLimit) begin
      n.idleMs = s.idleMs + 1'b1;
      if (n.idleMs == idleLimit) begin
        commEvt = 1'b1;
      end
    end

    // a new event wins over a clear in the same cycle
    n.commFault = commEvt | (s.commFault & !faultClear);
    n.stopDrive = n.commFault & s.faultPolicy;
    if (commEvt || driveFaultEvt) begin
      n.hist2 = s.hist1;
      n.hist1 = s.hist0;
      n.hist0 = commEvt ? `SSCC_COMM_FAULT_CODE : driveFaultCode;
    end
    n.diOut = (s.srcMask & s.softIn) | (~s.srcMask & s.dinS2);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.rxS1 <= 1'b1;
      s.rxS2 <= 1'b1;
      s.txPin <= 1'b1;
      s.stationAddr <= `SSCC_RST_STATION;
      s.baudSel <= `SSCC_RST_BAUD;
      s.protoSel <= `SSCC_RST_PROTO;
    end else begin
      s <= n;
    end
  end
endmodule

//--- testbench/serial_slave_comm_config_tb_top.sv
// self-checking bench for the serial slave port
`timescale 1ns/1ns
`include "sscc_consts.svh"
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin \
  nFail++; $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); end end
module serial_slave_comm_config_tb_top;
  localparam int MS = 10;
  localparam int DIV = 10000000 / 115200;
  localparam logic [15:0] RA [11] = '{16'h0300, 16'h0301, 16'h0302,
    16'h0303, 16'h0304, 16'h0305, 16'h0306, 16'h0307, 16'h0400,
    16'h0401, 16'h0402};
  localparam logic [15:0] RV [11] = '{1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  localparam logic [15:0] BA [5] = '{16'h0301, 16'h0302, 16'h0303,
    16'h0304, 16'h0306};
  localparam logic [15:0] BB [5] = '{6, 9, 2, 16'h15, 16'h40};
  localparam logic [15:0] BM [5] = '{5, 8, 1, 16'h14, 16'h3f};
  localparam logic [15:0] BR [5] = '{1, 0, 0, 0, 0};
  logic core_clk, rst_n, rxdPin, txdPin, rxCharValid, rxCharReady;
  logic txCharValid, txCharReady, rtuMode, reqValid, reqReady, reqWrite;
  logic rspValid, rspError, driveFaultEvt, faultClear, commFault, stopDrive;
  logic [5:0] extDin, diState;
  logic [7:0] rxCharData, txCharData, reqStation, stn;
  logic [15:0] reqReg, reqData, rspData, driveFaultCode, rData;
  logic rErr, rdy1;
  logic [9:0] txw;
  int lat, nFail, samplesChecked;

  sscc_port #(.MS_CYCLES(MS)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .rxdPin(rxdPin), .txdPin(txdPin), .extDin(extDin), .diState(diState),
    .rxCharValid(rxCharValid), .rxCharReady(rxCharReady),
    .rxCharData(rxCharData), .txCharValid(txCharValid),
    .txCharReady(txCharReady), .txCharData(txCharData), .rtuMode(rtuMode),
    .reqValid(reqValid), .reqReady(reqReady), .reqStation(reqStation),
    .reqWrite(reqWrite), .reqReg(reqReg), .reqData(reqData),
    .rspValid(rspValid), .rspData(rspData), .rspError(rspError),
    .driveFaultEvt(driveFaultEvt), .driveFaultCode(driveFaultCode),
    .faultClear(faultClear), .commFault(commFault), .stopDrive(stopDrive));
  sscc_host_model host (.core_clk(core_clk), .rxdPin(rxdPin));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // lat is cycles from take to answer, 0 when none came
  task automatic acc(input logic [7:0] st, input logic w,
    input logic [15:0] a, input logic [15:0] d);
    int n;
    @(negedge core_clk);
    while (reqReady !== 1'b1) @(negedge core_clk);
    {reqStation, reqWrite, reqReg, reqData} = {st, w, a, d};
    reqValid = 1'b1;
    @(negedge core_clk);
    reqValid = 1'b0;
    rdy1 = reqReady;
    lat = 0;
    for (n = 1; n <= 400 && lat == 0; n++) begin
      if (rspValid === 1'b1) begin
        lat = n;
        rData = rspData;
        rErr = rspError;
      end else @(negedge core_clk);
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    acc(stn, 1'b0, a, 16'h0000);
    `CHK(rData, e)
    `CHK(rErr, 1'b0)
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d,
    input logic e);
    acc(stn, 1'b1, a, d);
    `CHK(rErr, e)
  endtask

  task automatic take_char(input logic [7:0] e);
    int n;
    for (n = 0; n < 300 && rxCharValid !== 1'b1; n++) @(negedge core_clk);
    `CHK(rxCharData, e)
    rxCharReady = 1'b1;
    @(negedge core_clk);
    rxCharReady = 1'b0;
    `CHK(rxCharValid, 1'b0)
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    nFail++;
    report_and_stop();
  end

  initial begin
    int i;
    {rst_n, rxCharReady, txCharValid, reqValid, reqWrite} = '0;
    {driveFaultEvt, faultClear, extDin, txCharData} = '0;
    {reqStation, reqReg, reqData, driveFaultCode} = '0;
    {nFail, samplesChecked} = '0;
    stn = 8'h01;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    for (i = 0; i < 11; i++) begin
      rd(RA[i], RV[i]);
    end
    acc(stn, 1'b0, 16'h0308, 16'h0000);
    `CHK(rErr, 1'b1)
    wr(16'h0400, 16'h0005, 1'b1);
    for (i = 0; i < 5; i++) begin
      wr(BA[i], BB[i], 1'b1);
      rd(BA[i], BR[i]);
      wr(BA[i], BM[i], 1'b0);
      rd(BA[i], BM[i]);
      wr(BA[i], BR[i], 1'b0);
    end
    wr(16'h0300, 16'h0000, 1'b1);
    wr(16'h0300, 16'h00ff, 1'b1);
    wr(16'h0300, 16'h00fe, 1'b0);
    acc(8'h01, 1'b0, 16'h0300, 16'h0000);
    `CHK(lat, 0)
    stn = 8'hfe;
    wr(16'h0307, 16'h0003, 1'b0);
    acc(stn, 1'b0, 16'h0307, 16'h0000);
    `CHK(rdy1, 1'b0)
    `CHK(lat, 3 * MS + 1)
    `CHK(rData, 16'h0003)
    acc(8'hff, 1'b0, 16'h0300, 16'h0000);
    `CHK(lat, 1)
    `CHK(rData, 16'h00fe)
    acc(8'h00, 1'b1, 16'h0307, 16'h0000);
    `CHK(lat, 0)
    rd(16'h0307, 16'h0000);
    extDin = 6'h2a;
    wr(16'h0306, 16'h0003, 1'b0);
    wr(16'h0407, 16'h0001, 1'b0);
    repeat (3) @(negedge core_clk);
    `CHK(diState, 6'h29)
    rd(16'h0407, 16'h0029);
    wr(16'h0306, 16'h003f, 1'b0);
    wr(16'h0407, 16'h0015, 1'b0);
    repeat (3) @(negedge core_clk);
    `CHK(diState, 6'h15)
    wr(16'h0301, 16'h0005, 1'b0);
    for (i = 0; i < 9; i++) begin
      wr(16'h0302, i[15:0], 1'b0);
      `CHK(rtuMode, (i >= 6))
      host.send(8'hc3, DIV, i >= 3, i % 3 != 0, i % 3 == 2, i % 3 == 0, 0);
      take_char((i >= 3) ? 8'hc3 : 8'h43);
      `CHK(commFault, 1'b0)
    end
    wr(16'h0303, 16'h0001, 1'b0);
    host.send(8'h3c, DIV, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    repeat (300) @(negedge core_clk);
    `CHK(rxCharValid, 1'b0)
    `CHK(commFault, 1'b1)
    `CHK(stopDrive, 1'b1)
    driveFaultCode = 16'h0abc;
    driveFaultEvt = 1'b1;
    @(negedge core_clk);
    driveFaultEvt = 1'b0;
    faultClear = 1'b1;
    @(negedge core_clk);
    faultClear = 1'b0;
    wr(16'h0303, 16'h0000, 1'b0);
    `CHK(commFault, 1'b0)
    `CHK(stopDrive, 1'b0)
    rd(16'h0400, 16'h0abc);
    rd(16'h0401, `SSCC_COMM_FAULT_CODE);
    wr(16'h0304, 16'h0001, 1'b0);
    repeat (9900) @(negedge core_clk);
    `CHK(commFault, 1'b0)
    repeat (200) @(negedge core_clk);
    `CHK(commFault, 1'b1)
    wr(16'h0304, 16'h0000, 1'b0);
    rd(16'h0402, `SSCC_COMM_FAULT_CODE);
    wr(16'h0302, 16'h0007, 1'b0);
    txw = {1'b1, ^8'h5a, 8'h5a};
    txCharData = 8'h5a;
    `CHK(txCharReady, 1'b1)
    txCharValid = 1'b1;
    @(negedge core_clk);
    txCharValid = 1'b0;
    `CHK(txdPin, 1'b0)
    for (i = 0; i < 10; i++) begin
      repeat (DIV) @(negedge core_clk);
      `CHK(txdPin, txw[i])
    end
    repeat (DIV) @(negedge core_clk);
    `CHK(txCharReady, 1'b1)
    report_and_stop();
  end
endmodule

//--- testbench/sscc_host_model.sv
// host side of the serial link: frames characters onto the receive line
`timescale 1ns/1ns
module sscc_host_model (
  input wire logic core_clk,
  output logic rxdPin
);
  // line idles at mark level between frames
  initial rxdPin = 1'b1;

  // only one drive sits on this bus, so its address is unique
  task automatic send(input logic [7:0] ch, input int div,
    input logic eight, input logic parEn, input logic parOdd,
    input logic twoStop, input logic badPar);
    int i;
    logic par;
    par = (eight ? ^ch : ^ch[6:0]) ^ parOdd ^ badPar;
    rxdPin = 1'b0;
    repeat (div) @(negedge core_clk);
    // data lsb first, then parity, then stops
    for (i = 0; i < (eight ? 8 : 7); i++) begin
      rxdPin = ch[i];
      repeat (div) @(negedge core_clk);
    end
    if (parEn) begin
      rxdPin = par;
      repeat (div) @(negedge core_clk);
    end
    rxdPin = 1'b1;
    repeat (twoStop ? 2 * div : div) @(negedge core_clk);
  endtask
endmodule

//--- testbench/sscc_port_assertions.sv
// concurrent checks on the serial slave port pins
`timescale 1ns/1ns
module sscc_port_assertions #(
  parameter int MS_CYCLES = 10000
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic txdPin,
  input wire logic rxCharValid,
  input wire logic rxCharReady,
  input wire logic [7:0] rxCharData,
  input wire logic txCharValid,
  input wire logic txCharReady,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic [7:0] reqStation,
  input wire logic rspValid,
  input wire logic [15:0] rspData,
  input wire logic rspError,
  input wire logic faultClear,
  input wire logic commFault,
  input wire logic stopDrive
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence bcastTake;
    reqValid && reqReady && reqStation == 8'h00;
  endsequence
  sequence autoTake;
    reqValid && reqReady && reqStation == 8'hff;
  endsequence
  sequence txTake;
    txCharValid && txCharReady;
  endsequence
  // eight quiet cycles is enough: a broadcast never queues an answer
  sequence quietRsp;
    !rspValid [*8];
  endsequence

  bcast_no_answer_a: assert property (bcastTake |=> quietRsp)
    else $error("broadcast request was answered");
  auto_answer_a: assert property (
    autoTake |=> rspValid)
    else $error("request to 255 not answered at once");
  // fault and stop load on the same edge, so compare in the same cycle
  stop_policy_a: assert property (stopDrive |-> commFault)
    else $error("drive stopped without a link fault");
  fault_sticky_a: assert property (
    commFault && !faultClear |=> commFault)
    else $error("link fault vanished without a clear");
  tx_start_a: assert property (
    txTake |=> !txdPin && !txCharReady)
    else $error("start bit missing after character take");
  tx_idle_a: assert property (txCharReady |-> txdPin)
    else $error("transmit line low while idle");
  rx_hold_a: assert property (
    rxCharValid && !rxCharReady |=> rxCharValid && $stable(rxCharData))
    else $error("received character changed before it was taken");
  // answer fields load at the take, even when the pulse comes later
  rsp_hold_a: assert property (
    !rspValid && !$past(reqValid && reqReady)
      |-> $stable(rspData) && $stable(rspError))
    else $error("answer fields changed without an answer");
endmodule

bind sscc_port sscc_port_assertions #(.MS_CYCLES(MS_CYCLES)) chk (
  .core_clk(core_clk), .rst_n(rst_n), .txdPin(txdPin),
  .rxCharValid(rxCharValid), .rxCharReady(rxCharReady),
  .rxCharData(rxCharData), .txCharValid(txCharValid),
  .txCharReady(txCharReady), .reqValid(reqValid), .reqReady(reqReady),
  .reqStation(reqStation), .rspValid(rspValid), .rspData(rspData),
  .rspError(rspError), .faultClear(faultClear), .commFault(commFault),
  .stopDrive(stopDrive));
